// *** rtl/ai_sample_convert_timing.sv ***
// acquisition sample and conversion timing engine
// assumes synchronous register port and external signals asynchronous to core_clk
// Notes on behaviour
// RULE_01 - each accepted sample tick reads all channels
// RULE_02 - sample tick edge selectable rising or falling
// RULE_03 - internal tick from divider, counter, software
// RULE_04 - routed sample tick active high pulse
// RULE_05 - level mode holds line high whole sample
// RULE_06 - ignore sample ticks outside acquisition
// RULE_07 - hold gate masks sample ticks
// RULE_08 - start event starts divider; stop ends it
// RULE_09 - start to first tick delay, default two
// RULE_10 - external tick source respects convert timing
// RULE_11 - timebase 20 MHz, 100 kHz or external
// RULE_12 - each convert tick one conversion, edge selectable
// RULE_13 - convert divider reloads each tick per sample
// RULE_14 - routed convert tick is active low
// RULE_15 - sample to first convert delay, default three
// RULE_16 - gate all ticks until start event
// RULE_17 - ignore sample ticks until conversions complete
// RULE_18 - ignore convert ticks outside a sample
// RULE_19 - shared external signal converts every tick
// RULE_20 - posttrigger count loaded and decremented
// RULE_21 - pretrigger count then posttrigger count
// RULE_22 - early reference event ignored
// RULE_23 - software start emits start pulse
// RULE_24 - external inputs synchronised and edge detected
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module ai_sample_convert_timing (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire ai_timing_pkg::ext_in_s ext_in,
  output ai_timing_pkg::tick_out_s tick_out,
  output logic conv_pulse
);
  import ai_timing_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_m_q, rst_n_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // ----------------------------------------
  // input synchronisers and edge detect
  // ----------------------------------------
  ext_in_s s1_q, s2_q, s3_q;
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= ext_in; // RULE_24
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  ctrl_s ctrl_q;
  wire rise_sample = s2_q.ext_sample & ~s3_q.ext_sample;
  wire fall_sample = ~s2_q.ext_sample & s3_q.ext_sample;
  wire ext_sample_edge = ctrl_q.sample_edge_fall ? fall_sample : rise_sample; // RULE_02
  wire ext_conv_edge = ctrl_q.conv_edge_fall ?
    (~s2_q.ext_convert & s3_q.ext_convert) : (s2_q.ext_convert & ~s3_q.ext_convert); // RULE_12
  wire ext_base_edge = ctrl_q.base_edge_fall ?
    (~s2_q.ext_base & s3_q.ext_base) : (s2_q.ext_base & ~s3_q.ext_base);
  wire ext_start_edge = ctrl_q.start_edge_fall ?
    (~s2_q.ext_start & s3_q.ext_start) : (s2_q.ext_start & ~s3_q.ext_start);
  wire ext_ref_edge = ctrl_q.ref_edge_fall ?
    (~s2_q.ext_ref & s3_q.ext_ref) : (s2_q.ext_ref & ~s3_q.ext_ref);
  wire ctr_edge = s2_q.counter_out & ~s3_q.counter_out;
  wire hold_active = ctrl_q.hold_low ? ~s2_q.hold : s2_q.hold;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic [1:0] base_sel_q;
  logic [1:0] tick_src_q;
  logic [15:0] sample_div_q, conv_div_q, sample_dly_q, conv_dly_q;
  logic [15:0] conv_count_q, pre_count_q, post_count_q;
  logic [15:0] rdata_q;
  wire wr_ctrl = wr_stb & (addr == `REG_CTRL);
  wire wr_cmd = wr_stb & (addr == `REG_CMD);
  wire cmd_start = wr_cmd & wdata[`CMD_START];
  wire cmd_stop = wr_cmd & wdata[`CMD_STOP];
  wire cmd_soft_tick = wr_cmd & wdata[`CMD_SOFT_TICK];
  wire cmd_ref = wr_cmd & wdata[`CMD_REF];
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= '0;
      base_sel_q <= 2'h0;
      tick_src_q <= 2'h0;
      sample_div_q <= 16'h0001;
      conv_div_q <= 16'h0001;
      sample_dly_q <= `SAMPLE_DLY_RST;
      conv_dly_q <= `CONV_DLY_RST;
      conv_count_q <= 16'h0001;
      pre_count_q <= 16'h0000;
      post_count_q <= 16'h0001;
    end else if (wr_stb) begin
      unique case (addr)
        `REG_CTRL: ctrl_q <= wdata[12:0];
        `REG_SRC: begin
          base_sel_q <= wdata[1:0];
          tick_src_q <= wdata[3:2];
        end
        `REG_SAMPLE_DIV: sample_div_q <= wdata;
        `REG_CONV_DIV: conv_div_q <= wdata;
        `REG_SAMPLE_DLY: sample_dly_q <= wdata;
        `REG_CONV_DLY: conv_dly_q <= wdata;
        `REG_CONV_COUNT: conv_count_q <= wdata;
        `REG_PRE_COUNT: pre_count_q <= wdata;
        `REG_POST_COUNT: post_count_q <= wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // timebase selection
  // ----------------------------------------
  logic [7:0] slow_cnt_q;
  wire slow_tick = (slow_cnt_q == 8'((`SLOW_BASE_DIV) - 1));
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) slow_cnt_q <= 8'h00;
    else slow_cnt_q <= slow_tick ? 8'h00 : slow_cnt_q + 8'h01;
  end
  wire base_tick = (base_sel_q == BASE_FAST) ? 1'b1 :
                   (base_sel_q == BASE_SLOW) ? slow_tick : ext_base_edge; // RULE_11

  // ----------------------------------------
  // acquisition sequencing
  // ----------------------------------------
  acq_state_e state_q;
  logic [15:0] samples_q, div_cnt_q, conv_left_q, cdiv_q;
  logic dly_phase_q, cdly_phase_q, in_sample_q, start_pulse_q, conv_q, samp_pulse_q;
  wire start_evt = ctrl_q.enable &
    (ctrl_q.soft_start ? cmd_start : ext_start_edge);
  wire running = (state_q != ST_IDLE);
  wire div_fire = running & (tick_src_q == TICK_DIV) & base_tick & (div_cnt_q == 16'h0000);
  // raw sample tick from chosen source
  wire raw_sample = (tick_src_q == TICK_DIV) ? div_fire :
                    (tick_src_q == TICK_CTR) ? ctr_edge :
                    (tick_src_q == TICK_SOFT) ? cmd_soft_tick : ext_sample_edge; // RULE_03
  // gating: acquisition, hold, sample in progress
  wire sample_ok = raw_sample & running & ~hold_active & ~in_sample_q; // RULE_06 RULE_07 RULE_16 RULE_17
  wire int_conv = ctrl_q.conv_internal & in_sample_q & base_tick & (cdiv_q == 16'h0000);
  wire shared_conv = ctrl_q.shared_ext & sample_ok; // RULE_19
  wire conv_src = ctrl_q.shared_ext ? 1'b0 : (ctrl_q.conv_internal ? int_conv : ext_conv_edge);
  wire conv_ok = (conv_src & in_sample_q) | shared_conv; // RULE_18
  wire last_conv = (conv_left_q == 16'h0001) | (conv_left_q == 16'h0000);
  wire sample_done = ctrl_q.shared_ext ? shared_conv : (conv_ok & last_conv);
  wire last_sample = (samples_q == 16'h0001) & sample_ok;
  wire ref_evt = ctrl_q.soft_start ? cmd_ref : ext_ref_edge;

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      samples_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start_evt) begin
          state_q <= ctrl_q.pretrig ? ST_PRE : ST_POST;
          samples_q <= ctrl_q.pretrig ? pre_count_q : post_count_q; // RULE_20 RULE_21
        end
        ST_PRE: if (cmd_stop) state_q <= ST_IDLE;
          else if (sample_ok) begin
            if (samples_q <= 16'h0001) state_q <= ST_WAIT_REF;
            else samples_q <= samples_q - 16'h0001;
          end
        ST_WAIT_REF: if (cmd_stop) state_q <= ST_IDLE;
          else if (ref_evt) begin
            state_q <= ST_POST; // RULE_22
            samples_q <= post_count_q; // RULE_21
          end
        ST_POST: if (cmd_stop) state_q <= ST_IDLE;
          else if (sample_ok & ~ctrl_q.continuous) begin
            if (last_sample) state_q <= ST_IDLE; // RULE_08
            samples_q <= samples_q - 16'h0001; // RULE_20
          end
      endcase
    end
  end

  // sample divider with start delay
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_cnt_q <= 16'h0000;
      dly_phase_q <= 1'b0;
    end else if (start_evt & ~running) begin
      div_cnt_q <= sample_dly_q - 16'h0001; // RULE_08 RULE_09
      dly_phase_q <= 1'b1;
    end else if (running & base_tick) begin
      if (div_cnt_q != 16'h0000) div_cnt_q <= div_cnt_q - 16'h0001;
      else begin
        div_cnt_q <= sample_div_q - 16'h0001;
        dly_phase_q <= 1'b0;
      end
    end
  end

  // per-sample conversion tracking and convert divider
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      in_sample_q <= 1'b0;
      conv_left_q <= 16'h0000;
      cdiv_q <= 16'h0000;
      cdly_phase_q <= 1'b0;
    end else if (sample_ok & ~ctrl_q.shared_ext) begin
      in_sample_q <= 1'b1; // RULE_01
      conv_left_q <= conv_count_q;
      cdiv_q <= conv_dly_q - 16'h0001; // RULE_15
      cdly_phase_q <= 1'b1;
    end else if (sample_done | cmd_stop) begin
      in_sample_q <= 1'b0;
      cdiv_q <= conv_dly_q - 16'h0001; // RULE_13
    end else if (in_sample_q) begin
      if (conv_ok) conv_left_q <= conv_left_q - 16'h0001;
      if (ctrl_q.conv_internal & base_tick) begin
        if (cdiv_q != 16'h0000) cdiv_q <= cdiv_q - 16'h0001;
        else begin
          cdiv_q <= conv_div_q - 16'h0001; // RULE_13
          cdly_phase_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // output lines
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      start_pulse_q <= 1'b0;
      conv_q <= 1'b0;
      samp_pulse_q <= 1'b0;
    end else begin
      start_pulse_q <= start_evt & ~running & ctrl_q.soft_start; // RULE_23
      conv_q <= conv_ok; // RULE_12
      samp_pulse_q <= sample_ok; // RULE_04
    end
  end
  always_comb begin
    tick_out.sample_line = ctrl_q.level_out ? in_sample_q : samp_pulse_q; // RULE_04 RULE_05
    tick_out.convert_line_n = ~conv_q; // RULE_14
    tick_out.start_pulse = start_pulse_q;
    tick_out.running = running;
  end
  assign conv_pulse = conv_q;

  // ----------------------------------------
  // read back
  // ----------------------------------------
  wire [15:0] status = {12'h000, dly_phase_q, cdly_phase_q, in_sample_q, running};
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) rdata_q <= 16'h0000;
    else if (rd_stb) begin
      unique case (addr)
        `REG_CTRL: rdata_q <= {3'h0, ctrl_q};
        `REG_SRC: rdata_q <= {12'h000, tick_src_q, base_sel_q};
        `REG_SAMPLE_DIV: rdata_q <= sample_div_q;
        `REG_CONV_DIV: rdata_q <= conv_div_q;
        `REG_SAMPLE_DLY: rdata_q <= sample_dly_q;
        `REG_CONV_DLY: rdata_q <= conv_dly_q;
        `REG_CONV_COUNT: rdata_q <= conv_count_q;
        `REG_PRE_COUNT: rdata_q <= pre_count_q;
        `REG_POST_COUNT: rdata_q <= post_count_q;
        `REG_STATUS: rdata_q <= status;
        `REG_SAMPLES_LEFT: rdata_q <= samples_q;
        default: rdata_q <= 16'h0000;
      endcase
    end else rdata_q <= 16'h0000;
  end
  assign rdata = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  idle_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !running |-> !sample_ok) else $error("sample accepted while idle"); // RULE_06
  hold_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    hold_active |-> !sample_ok) else $error("sample accepted during hold"); // RULE_07
  busy_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    in_sample_q && !sample_done |=> !$rose(samp_pulse_q) || ctrl_q.shared_ext)
    else $error("sample during conversions"); // RULE_17
  conv_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    !in_sample_q && !ctrl_q.shared_ext |=> !conv_q) else $error("stray conversion"); // RULE_18
  conv_low_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    conv_q |-> !tick_out.convert_line_n) else $error("convert line not low"); // RULE_14
  soft_start_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    ctrl_q.soft_start && cmd_start && ctrl_q.enable && !running |=> tick_out.start_pulse)
    else $error("no start pulse"); // RULE_23
  post_load_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    state_q == ST_WAIT_REF && ref_evt && !cmd_stop |=> samples_q == $past(post_count_q))
    else $error("posttrigger count not loaded"); // RULE_21
  early_ref_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    state_q == ST_PRE |=> state_q != ST_POST) else $error("early reference taken"); // RULE_22
  start_load_a: assert property (@(posedge core_clk) disable iff (!rst_n_q)
    state_q == ST_IDLE && start_evt && !ctrl_q.pretrig |=> samples_q == $past(post_count_q))
    else $error("posttrigger load missing"); // RULE_20

  // ----------------------------------------
  // output line and counter checks
  // ----------------------------------------
  pulse_out_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_04
    !ctrl_q.level_out && sample_ok |=> tick_out.sample_line)
    else $error("sample pulse missing");
  level_out_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_05
    ctrl_q.level_out && in_sample_q |-> tick_out.sample_line)
    else $error("level output dropped");
  start_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_16
    state_q == ST_IDLE && !start_evt |=> state_q == ST_IDLE)
    else $error("run without start");
  shared_conv_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_19
    ctrl_q.shared_ext && sample_ok |=> conv_q)
    else $error("shared tick not converted");
  conv_reload_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_13
    int_conv && !sample_done && !cmd_stop |=> cdiv_q == $past(conv_div_q) - 16'h0001)
    else $error("convert divider not reloaded");
  start_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_09
    start_evt && !running |=> div_cnt_q == $past(sample_dly_q) - 16'h0001)
    else $error("start delay not loaded");
  conv_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_15
    sample_ok && !ctrl_q.shared_ext |=> cdiv_q == $past(conv_dly_q) - 16'h0001)
    else $error("convert delay not loaded");
  stop_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_08
    cmd_stop && running |=> !running)
    else $error("stop command ignored");
  post_dec_a: assert property (@(posedge core_clk) disable iff (!rst_n_q) // RULE_20
    state_q == ST_POST && sample_ok && !ctrl_q.continuous && !cmd_stop
    |=> samples_q == $past(samples_q) - 16'h0001)
    else $error("sample count not decremented");
endmodule // ai_sample_convert_timing

// *** rtl/ai_timing_pkg.sv ***
// types for the acquisition timing engine
// assumes ai_timing_regs.svh sits beside it
`include "ai_timing_regs.svh"
package ai_timing_pkg;
  typedef enum logic [1:0] {BASE_FAST, BASE_SLOW, BASE_EXT} base_sel_e;
  typedef enum logic [1:0] {TICK_DIV, TICK_CTR, TICK_SOFT, TICK_EXT} tick_src_e;
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_WAIT_REF, ST_POST} acq_state_e;
  typedef struct packed {
    logic enable;
    logic pretrig;
    logic continuous;
    logic soft_start;
    logic level_out;
    logic shared_ext;
    logic conv_internal;
    logic start_edge_fall;
    logic ref_edge_fall;
    logic hold_low;
    logic sample_edge_fall;
    logic conv_edge_fall;
    logic base_edge_fall;
  } ctrl_s;
  typedef struct packed {
    logic ext_sample;
    logic ext_convert;
    logic ext_base;
    logic ext_start;
    logic ext_ref;
    logic hold;
    logic counter_out;
  } ext_in_s;
  typedef struct packed {
    logic sample_line;
    logic convert_line_n;
    logic start_pulse;
    logic running;
  } tick_out_s;
endpackage

// *** rtl/ai_timing_regs.svh ***
// constants for the acquisition timing engine
// assumes inclusion from the package and the testbench
`ifndef AI_TIMING_REGS_SVH
`define AI_TIMING_REGS_SVH
`define REG_CTRL 4'h0
`define REG_SRC 4'h1
`define REG_SAMPLE_DIV 4'h2
`define REG_CONV_DIV 4'h3
`define REG_SAMPLE_DLY 4'h4
`define REG_CONV_DLY 4'h5
`define REG_CONV_COUNT 4'h6
`define REG_PRE_COUNT 4'h7
`define REG_POST_COUNT 4'h8
`define REG_CMD 4'h9
`define REG_STATUS 4'hA
`define REG_SAMPLES_LEFT 4'hB
`define CLK_HZ 20000000
`define SLOW_BASE_HZ 100000
`define SLOW_BASE_DIV (`CLK_HZ / `SLOW_BASE_HZ)
`define SAMPLE_DLY_RST 16'h0002
`define CONV_DLY_RST 16'h0003
`define CMD_START 0
`define CMD_STOP 1
`define CMD_SOFT_TICK 2
`define CMD_REF 3
`endif

// *** test/ext_source_model.sv ***
// far-side model: external tick, trigger, hold and timebase sources
// assumes requests arrive as one-cycle strobes on core_clk
`timescale 1ns/10ps
module ext_source_model (
  input wire logic core_clk,
  input wire logic [4:0] req,
  input wire logic hold_lvl,
  output ai_timing_pkg::ext_in_s ext_in
);
  import ai_timing_pkg::*;
  // ----------------------------------------
  // pulse stretchers, three cycles per event
  // ----------------------------------------
  logic [1:0] cnt_q [5];
  logic base_q;
  initial begin
    base_q = 1'b0;
    for (int i = 0; i < 5; i++) begin
      cnt_q[i] = 2'h0;
    end
  end
  always @(posedge core_clk) begin
    base_q <= ~base_q;
    for (int i = 0; i < 5; i++) begin
      cnt_q[i] <= req[i] ? 2'h3 : (cnt_q[i] != 2'h0 ? cnt_q[i] - 2'h1 : 2'h0);
    end
  end
  // sample ticks may be sent before the previous sample's conversions are done
  assign ext_in.ext_sample = (cnt_q[0] != 2'h0);
  assign ext_in.ext_convert = (cnt_q[1] != 2'h0);
  assign ext_in.ext_base = base_q;
  assign ext_in.ext_start = (cnt_q[2] != 2'h0);
  assign ext_in.ext_ref = (cnt_q[3] != 2'h0);
  assign ext_in.hold = hold_lvl;
  assign ext_in.counter_out = (cnt_q[4] != 2'h0);
endmodule // ext_source_model

// *** test/tb_ai_sample_convert_timing.sv ***
// testbench for the acquisition timing engine
// assumes the package, register header and far-side model are compiled first
`timescale 1ns/10ps
`include "ai_timing_regs.svh"
module tb_ai_sample_convert_timing;
  import ai_timing_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, hold_lvl = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic [4:0] req = 5'h00;
  ext_in_s ext_in;
  tick_out_s tick_out;
  logic conv_pulse, prev_s = 1'b0;
  int error_cnt = 0, checks_done = 0, ns = 0, nc = 0, ncl = 0, nsp = 0, nhi = 0;
  always #25 core_clk = ~core_clk;
  ai_sample_convert_timing uut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_in(ext_in), .tick_out(tick_out),
    .conv_pulse(conv_pulse));
  ext_source_model partner (.core_clk(core_clk), .req(req), .hold_lvl(hold_lvl), .ext_in(ext_in));
  // ----------------------------------------
  // output event counters
  // ----------------------------------------
  always @(posedge core_clk) begin
    prev_s <= tick_out.sample_line;
    if (tick_out.sample_line === 1'b1 && prev_s !== 1'b1) ns++;
    if (tick_out.sample_line === 1'b1) nhi++;
    if (conv_pulse === 1'b1) nc++;
    if (tick_out.convert_line_n === 1'b0) ncl++;
    if (tick_out.start_pulse === 1'b1) nsp++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
    chk(nm, e, v);
    @(posedge core_clk);
  endtask
  task automatic fire(input int which);
    req[which] <= 1'b1;
    @(posedge core_clk);
    req[which] <= 1'b0;
    cyc(12);
  endtask
  task automatic clr();
    #1;
    ns = 0; nc = 0; ncl = 0; nsp = 0; nhi = 0;
  endtask
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (tick_out.running !== 1'b0 && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    cyc(20);
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #(50 * 20000);
    error_cnt++;
    $display("MISMATCH watchdog expected finish seen timeout");
    print_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(6);
    rstn <= 1'b1;
    cyc(4);
    chk("convert_line_n_rst", 16'h1, {15'h0, tick_out.convert_line_n});
    rdc("sample_dly_rst", `REG_SAMPLE_DLY, 16'h0002);
    rdc("conv_dly_rst", `REG_CONV_DLY, 16'h0003);
    wr(4'hF, 16'h1234);
    rdc("unmapped", 4'hF, 16'h0000);
    // posttrigger, external sample and convert ticks
    wr(`REG_SRC, 16'h000C);
    wr(`REG_CONV_COUNT, 16'h0002);
    wr(`REG_POST_COUNT, 16'h0002);
    wr(`REG_CTRL, 16'h1200);
    clr();
    fire(0);
    chk("tick_before_start", 16'h0, ns[15:0]);
    wr(`REG_CMD, 16'h0001);
    cyc(3);
    chk("start_pulse", 16'h1, nsp[15:0]);
    chk("running", 16'h1, {15'h0, tick_out.running});
    rdc("samples_left_load", `REG_SAMPLES_LEFT, 16'h0002);
    fire(1);
    chk("conv_before_sample", 16'h0, nc[15:0]);
    fire(0);
    fire(0);
    chk("sample_during_sample", 16'h1, ns[15:0]);
    repeat (3) fire(1);
    chk("conv_per_sample", 16'h2, nc[15:0]);
    chk("convert_line_lows", 16'h2, ncl[15:0]);
    rdc("samples_left_dec", `REG_SAMPLES_LEFT, 16'h0001);
    hold_lvl <= 1'b1;
    cyc(4);
    fire(0);
    chk("held_sample", 16'h1, ns[15:0]);
    hold_lvl <= 1'b0;
    cyc(4);
    fire(0);
    repeat (2) fire(1);
    chk("post_done", 16'h0, {15'h0, tick_out.running});
    fire(0);
    chk("tick_when_idle", 16'h2, ns[15:0]);
    // pretrigger, shared external line, falling sample edge
    wr(`REG_CONV_COUNT, 16'h0001);
    wr(`REG_PRE_COUNT, 16'h0001);
    wr(`REG_POST_COUNT, 16'h0001);
    wr(`REG_CTRL, 16'h1A84);
    wr(`REG_CMD, 16'h0001);
    clr();
    wr(`REG_CMD, 16'h0008);
    cyc(4);
    fire(0);
    chk("shared_conv", 16'h1, nc[15:0]);
    fire(0);
    chk("wait_ref_running", 16'h1, {15'h0, tick_out.running});
    wr(`REG_CMD, 16'h0008);
    cyc(4);
    fire(0);
    chk("pre_post_done", 16'h0, {15'h0, tick_out.running});
    chk("shared_conv_all", 16'h3, nc[15:0]);
    // internal divider, internal convert divider, level output
    wr(`REG_SRC, 16'h0000);
    wr(`REG_SAMPLE_DIV, 16'h0004);
    rdc("sample_div", `REG_SAMPLE_DIV, 16'h0004);
    wr(`REG_CONV_DIV, 16'h0002);
    wr(`REG_CONV_COUNT, 16'h0002);
    wr(`REG_POST_COUNT, 16'h0002);
    wr(`REG_CTRL, 16'h1340);
    clr();
    wr(`REG_CMD, 16'h0001);
    wait_idle(500);
    chk("div_samples", 16'h2, ns[15:0]);
    chk("div_convs", 16'h4, nc[15:0]);
    chk("level_high", 16'h1, {15'h0, nhi > 2});
    // continuous, software tick, counter tick, stop command
    wr(`REG_SRC, 16'h0008);
    wr(`REG_CONV_DIV, 16'h0001);
    wr(`REG_CONV_COUNT, 16'h0001);
    wr(`REG_CTRL, 16'h1640);
    wr(`REG_CMD, 16'h0001);
    clr();
    cyc(5);
    wr(`REG_CMD, 16'h0004);
    cyc(30);
    chk("soft_tick", 16'h1, ns[15:0]);
    chk("soft_conv", 16'h1, nc[15:0]);
    wr(`REG_SRC, 16'h0004);
    fire(4);
    cyc(20);
    chk("counter_tick", 16'h2, ns[15:0]);
    wr(`REG_CMD, 16'h0002);
    cyc(4);
    chk("stopped", 16'h0, {15'h0, tick_out.running});
    print_verdict();
  end
endmodule // tb_ai_sample_convert_timing
